//--- dv/amp_protection_fault_manager_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "apfm_consts.vh"
module amp_protection_fault_manager_bench;
  // ----
  // Stimulus and wiring
  // ----
  logic        clock = 1'b0, rst_n = 1'b0, resetReq = 1'b0, pwmFrame = 1'b0;
  logic [3:0]  ocHigh = 4'h0, ocLow = 4'h0, bootUv = 4'h0;
  logic [1:0]  dcImbalance = 2'h0;  // Driven by the DC scenario
  logic        supplyUv = 1'b0, heatWarning = 1'b0, heatShutdown = 1'b0;
  logic        shortGnd = 1'b0, shortSupply = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rnd;
  logic        pready, pslverr, psTestSupply, faultOut, faultOe;
  logic        warnOut, warnOe, resetIn_n, faultPin_n;
  logic [3:0]  bridgeEnable, bridgeFlip;
  logic [1:0]  tripLevel;
  logic [33:0] expQ [$];  // Pending answers: write, error, data
  int          errTotal = 0, nChecks = 0, cyc = 0;
  always #2 clock = ~clock;
  apfm_core dut (.clock, .rst_n, .resetIn_n, .pwmFrame, .ocHigh, .ocLow,
    .dcImbalance, .bootUv, .supplyUv, .heatWarning, .heatShutdown, .shortGnd,
    .shortSupply, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .bridgeEnable, .bridgeFlip, .tripLevel, .psTestSupply,
    .faultOut, .faultOe, .warnOut, .warnOe);
  apfm_mcu_model #(.HOLD_CYC(200)) mcu (.clock, .faultOe, .faultOut,
    .resetReq, .resetIn_n, .faultPin_n);
  // ----
  // Helpers
  // ----
  task automatic chk(input string nm, input logic [31:0] ex, got);
    nChecks++;
    if (got !== ex) begin
      errTotal++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Request held until ready is seen high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [32:0] ex);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    expQ.push_back({wr, ex});
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic ocEvt(input logic [3:0] h, l);
    ocHigh <= h;
    ocLow <= l;
    @(posedge clock);
    ocHigh <= 4'h0;
    ocLow <= 4'h0;
    // Latch, then pin: third edge so checks see settled outputs
    repeat (3) @(posedge clock);
  endtask
  task automatic frame();
    pwmFrame <= 1'b1;
    @(posedge clock);
    pwmFrame <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  task automatic mcuReset(input logic pinEx);
    resetReq <= 1'b1;
    @(posedge clock);
    resetReq <= 1'b0;
    repeat (3) @(posedge clock);
    chk("pin in reset", {31'h0, pinEx}, {31'h0, faultPin_n});
    while (resetIn_n !== 1'b1) @(posedge clock);
    repeat (3) @(posedge clock);
  endtask
  task automatic summarize();
    if (errTotal == 0 && nChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Answer watcher: oldest note against each ready
  always @(posedge clock) begin : watch
    logic [33:0] e;
    if (pready === 1'b1 && expQ.size() > 0) begin
      e = expQ.pop_front();
      chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
      if (!e[33]) chk("prdata", e[31:0], prdata);
    end
  end
  // Hang guard, far above the expected few thousand cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errTotal++;
      summarize();
    end
  end
  // ----
  // Scenarios
  // ----
  initial begin
    rnd = $urandom(32'h5cc4);
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    mcuReset(1'b0);
    chk("supply step", 32'h0, {31'h0, psTestSupply});
    while (psTestSupply !== 1'b1) @(posedge clock);
    shortSupply <= 1'b1;
    repeat (300) @(posedge clock);
    chk("pin short", 32'h0, {31'h0, faultPin_n});
    chk("enables short", 32'h0, {28'h0, bridgeEnable});
    shortSupply <= 1'b0;
    while (faultPin_n !== 1'b1) @(posedge clock);
    repeat (2) @(posedge clock);
    chk("enables run", 32'hf, {28'h0, bridgeEnable});
    apb(1'b0, 12'h000, 32'h0, 33'h0);
    apb(1'b0, 12'h008, 32'h0, 33'h0);
    apb(1'b1, 12'h00c, 32'h0, 33'h1_0000_0000);
    apb(1'b0, 12'h010, 32'h0, 33'h1_0000_0000);
    for (int c = 0; c < 16; c++) begin
      rnd = $urandom;
      apb(1'b1, 12'h000, {25'h0, rnd[0], c[3:0], 2'h0}, 33'h0);
      apb(1'b0, 12'h000, 32'h0, {27'h0, c[3:0], 2'h0});
      chk("tripLevel", (c < 8) ? c % 4 : 3, {30'h0, tripLevel});
    end
    apb(1'b1, 12'h000, 32'h0, 33'h0);
    ocEvt(4'h1, 4'h0);
    chk("bridgeFlip", 32'h1, {28'h0, bridgeFlip});
    apb(1'b0, 12'h008, 32'h0, 33'h1);
    frame();
    chk("bridgeFlip", 32'h0, {28'h0, bridgeFlip});
    frame();
    apb(1'b0, 12'h008, 32'h0, 33'h0);
    repeat (`APFM_OL_MAX - 1) ocEvt(4'h1, 4'h0);
    chk("pin below max", 32'h1, {31'h0, faultPin_n});
    ocEvt(4'h1, 4'h0);
    chk("pin at max", 32'h0, {31'h0, faultPin_n});
    chk("enables at max", 32'hc, {28'h0, bridgeEnable});
    mcuReset(1'b1);
    apb(1'b1, 12'h000, 32'h10, 33'h0);
    ocEvt(4'h0, 4'h4);
    chk("enables latched", 32'h3, {28'h0, bridgeEnable});
    mcuReset(1'b1);
    chk("enables cleared", 32'hf, {28'h0, bridgeEnable});
    supplyUv <= 1'b1;
    repeat (3) @(posedge clock);
    chk("pin uv", 32'h0, {31'h0, faultPin_n});
    chk("enables uv", 32'h0, {28'h0, bridgeEnable});
    supplyUv <= 1'b0;
    bootUv <= 4'h2;
    repeat (3) @(posedge clock);
    chk("pin boot", 32'h1, {31'h0, faultPin_n});
    chk("enables boot", 32'hd, {28'h0, bridgeEnable});
    bootUv <= 4'h0;
    heatWarning <= 1'b1;
    repeat (3) @(posedge clock);
    chk("warnOe", 32'h1, {31'h0, warnOe});
    chk("warnOut", 32'h0, {31'h0, warnOut});
    heatWarning <= 1'b0;
    heatShutdown <= 1'b1;
    @(posedge clock);
    heatShutdown <= 1'b0;
    repeat (5) @(posedge clock);
    chk("pin thermal", 32'h0, {31'h0, faultPin_n});
    mcuReset(1'b1);
    chk("pin resumed", 32'h1, {31'h0, faultPin_n});
    chk("enables resumed", 32'hf, {28'h0, bridgeEnable});
    // DC imbalance: ignored in parallel mode, counts in bridge-tied
    apb(1'b1, 12'h000, 32'h2, 33'h0);
    dcImbalance <= 2'h2;
    repeat (24) @(posedge clock);
    chk("enables dc parallel_bridge", 32'hf, {28'h0, bridgeEnable});
    apb(1'b1, 12'h000, 32'h0, 33'h0);
    repeat (24) @(posedge clock);
    dcImbalance <= 2'h0;
    repeat (3) @(posedge clock);
    chk("enables dc btl", 32'h3, {28'h0, bridgeEnable});
    chk("pin dc", 32'h0, {31'h0, faultPin_n});
    summarize();
  end
endmodule // amp_protection_fault_manager_bench
`default_nettype wire

//--- dv/apfm_core_sva.sv
`timescale 1ns/10ps
`default_nettype none
module apfm_core_sva (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        resetIn_n,
  input wire logic        pwmFrame,
  input wire logic [3:0]  ocHigh,
  input wire logic [3:0]  ocLow,
  input wire logic [3:0]  bootUv,
  input wire logic        supplyUv,
  input wire logic        heatWarning,
  input wire logic        heatShutdown,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  bridgeEnable,
  input wire logic [3:0]  bridgeFlip,
  input wire logic        faultOe,
  input wire logic        warnOe
);
  // ----
  // Checks, one clock domain
  // ----
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_uv_report: assert property (supplyUv && resetIn_n |=> faultOe)
    else $error("report missing on undervoltage");
  a_uv_all_off: assert property (supplyUv |=> bridgeEnable == 4'h0)
    else $error("bridge on during undervoltage");
  a_boot_local: assert property (bootUv != 4'h0 |=>
    (bridgeEnable & $past(bootUv)) == 4'h0) else $error("boot bridge on");
  a_therm_hold: assert property (heatShutdown ##1
    (resetIn_n && !heatShutdown) [*3] |-> faultOe && bridgeEnable == 4'h0)
    else $error("thermal latch lost");
  a_warn_set: assert property (heatWarning |=> warnOe)
    else $error("warning not driven");
  a_flip_clear: assert property (pwmFrame && ocHigh == 4'h0 &&
    ocLow == 4'h0 |-> ##2 bridgeFlip == 4'h0) else $error("flip kept");
  // Slave answers one cycle after setup and only then
  a_ready_once: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready timing");
  a_unmapped_err: assert property (psel && !penable && paddr > 12'h008
    |=> pslverr) else $error("no error on unmapped");
  cover property (supplyUv ##1 faultOe);
  cover property ($rose(bridgeFlip[0]));
  cover property (pready && pslverr);
endmodule // apfm_core_sva
bind apfm_core apfm_core_sva u_sva (.clock, .rst_n, .resetIn_n, .pwmFrame,
  .ocHigh, .ocLow, .bootUv, .supplyUv, .heatWarning, .heatShutdown, .psel,
  .penable, .paddr, .pready, .pslverr, .bridgeEnable, .bridgeFlip,
  .faultOe, .warnOe);
`default_nettype wire

//--- dv/apfm_mcu_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// Controller stand-in: reads report pin, drives reset pin
// ----
module apfm_mcu_model #(
  parameter int HOLD_CYC = 200  // Guard after a report, scaled from 4 ms
) (
  input  wire logic clock,
  input  wire logic faultOe,
  input  wire logic faultOut,
  input  wire logic resetReq,
  output var  logic resetIn_n,
  output wire logic faultPin_n
);
  int   sinceFall = HOLD_CYC;  // Cycles since pin fell
  logic pinLast   = 1'b1;      // Pin one cycle ago
  // Released pin floats to the pull-up level
  assign faultPin_n = faultOe ? faultOut : 1'b1;
  initial resetIn_n = 1'b1;
  // Early release would restart a hot device, so wait out the guard
  always @(posedge clock) begin
    pinLast <= faultPin_n;
    if (pinLast && !faultPin_n) sinceFall <= 0;
    else if (sinceFall < HOLD_CYC) sinceFall <= sinceFall + 1;
    if (resetReq) resetIn_n <= 1'b0;
    else if (sinceFall >= HOLD_CYC) resetIn_n <= 1'b1;
  end
endmodule // apfm_mcu_model
`default_nettype wire

//--- rtl/apfm_consts.vh
`ifndef APFM_CONSTS_VH
`define APFM_CONSTS_VH
// Register byte offsets
`define APFM_CTRL_OFF    12'h000
`define APFM_STATUS_OFF  12'h004
`define APFM_OLCNT_OFF   12'h008
// Control field positions
`define APFM_CTRL_MODE_LSB 0
`define APFM_CTRL_MODE_MSB 1
`define APFM_CTRL_OCSEL_LSB 2
`define APFM_CTRL_OCSEL_MSB 5
`define APFM_CTRL_PSDONE_BIT 6
// Reset values
`define APFM_CTRL_RST    32'h0000_0000
// Output configurations
`define APFM_CFG_BTL     2'h0
`define APFM_CFG_MIXED   2'h1
`define APFM_CFG_PARALLEL_BRIDGE    2'h2
`define APFM_CFG_SE      2'h3
// Overcurrent select codes: 0..3 cycle limit, 4..7 latched, others invalid
`define APFM_OCSEL_CLIM_LO 4'h0
`define APFM_OCSEL_CLIM_HI 4'h3
`define APFM_OCSEL_LAT_LO  4'h4
`define APFM_OCSEL_LAT_HI  4'h7
`define APFM_LEVEL_MIN     2'h3
// Overload counter terminal count
`define APFM_OL_MAX        8'h10
// Pin-short check step length in ns (arbitrary plain default)
`define APFM_PS_STEP_NS    4000
`define APFM_CLK_NS        4
`define APFM_PS_STEP_CYC   ((`APFM_PS_STEP_NS + `APFM_CLK_NS - 1) / `APFM_CLK_NS)
`endif

//--- rtl/apfm_core.v
// Implementation choices: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Any shutdown fault: outputs Hi-Z, report low
// - Non-latched faults clear themselves when gone
// - Bootstrap undervoltage disables only its half bridge
// - Overcurrent flags per switch, limit or latch
// - Cycle-limit flips bridge until next frame
// - Counter up on event, down on clean frame
// - Counter at maximum latches channel off
// - Latched mode shuts down on first event
// - Select code picks mode and trip level
// - Invalid select uses lowest trip level
// - DC imbalance counts; off in parallel/single-ended
// - Pin-short check only at startup
// - Check ground shorts, then supply shorts
// - Short found: all Hi-Z until removed
// - Check holds report low, ignores reset
// - Reset never reruns check; no single-ended
// - Heat warning drives warning output low
// - Thermal shutdown latched, all Hi-Z, report
// - Only reset clears thermal shutdown
// - Power-on clear resets overload state
// - Supply undervoltage: all Hi-Z, report low
// - Resume when all undervoltage flags clear
// - Reset low forces report output high
// - Report and warning are open-drain active-low
`include "apfm_consts.vh"

module apfm_core (
  input  wire        clock,        // 250 MHz core clock
  input  wire        rst_n,        // Power-on clear, async
  input  wire        resetIn_n,    // Device reset pin level
  input  wire        pwmFrame,     // Pulse at start of PWM frame
  input  wire [3:0]  ocHigh,       // High-side overcurrent flags
  input  wire [3:0]  ocLow,        // Low-side overcurrent flags
  input  wire [1:0]  dcImbalance,  // Per BRIDGE_TIED channel DC flags
  input  wire [3:0]  bootUv,       // Bootstrap undervoltage per bridge
  input  wire        supplyUv,     // Any low-voltage or gate supply low
  input  wire        heatWarning,  // Junction above warning level
  input  wire        heatShutdown, // Junction above shutdown level
  input  wire        shortGnd,     // Some output shorted to ground
  input  wire        shortSupply,  // Some output shorted to supply
  input  wire        psel,         // APB select
  input  wire        penable,      // APB enable
  input  wire        pwrite,       // APB direction
  input  wire [11:0] paddr,        // APB byte address
  input  wire [31:0] pwdata,       // APB write data
  output reg  [31:0] prdata,       // APB read data
  output reg         pready,       // APB ready
  output reg         pslverr,      // APB error
  output reg  [3:0]  bridgeEnable, // Half bridge may switch
  output reg  [3:0]  bridgeFlip,   // Half bridge output inverted
  output reg  [1:0]  tripLevel,    // Comparator trip level, 0 highest
  output reg         psTestSupply, // Check in supply step
  output reg         faultOut,     // Report pin drive value
  output reg         faultOe,      // Report pin drive enable
  output reg         warnOut,      // Warning pin drive value
  output reg         warnOe        // Warning pin drive enable
);

  // ----------------------------------------------------------------
  // Pin-short check states
  // ----------------------------------------------------------------
  localparam [3:0] PS_GND  = 4'b0001; // Test ground shorts
  localparam [3:0] PS_SUP  = 4'b0010; // Test supply shorts
  localparam [3:0] PS_DONE = 4'b0100; // Startup finished
  localparam [3:0] PS_SKIP = 4'b1000; // Unused spare code
  localparam [15:0] STEP_CYC = `APFM_PS_STEP_CYC;

  reg  [31:0] ctrl_reg;              // Control register
  reg  [3:0]  psState_reg;           // Check state
  reg  [15:0] psCount_reg;           // Step timer
  reg  [7:0]  olCount_reg [0:1];     // Overload counters per channel
  reg  [1:0]  chanLatch_reg;         // Channel latched off
  reg         thermLatch_reg;        // Thermal shutdown latch
  reg  [3:0]  flip_reg;              // Frame-local flip per bridge
  reg  [1:0]  chanOc_reg;            // Overload event (cycle-limit OC or DC) seen this frame
  reg         resetPrev_reg;         // Previous reset pin level

  wire [1:0]  cfg     = ctrl_reg[`APFM_CTRL_MODE_MSB:`APFM_CTRL_MODE_LSB];
  wire [3:0]  ocSel   = ctrl_reg[`APFM_CTRL_OCSEL_MSB:`APFM_CTRL_OCSEL_LSB];
  wire        psOk    = ctrl_reg[`APFM_CTRL_PSDONE_BIT];
  wire [3:0]  ocAny   = ocHigh | ocLow;
  wire        psBusy  = (psState_reg != PS_DONE);
  wire        resetLow = ~resetIn_n & ~psBusy;
  wire        resetRise = resetIn_n & ~resetPrev_reg & ~psBusy;
  // Mode and level decode from the select code
  wire        selClim = (ocSel <= `APFM_OCSEL_CLIM_HI);
  wire        selLat  = (ocSel >= `APFM_OCSEL_LAT_LO) &&
                        (ocSel <= `APFM_OCSEL_LAT_HI);
  wire        cycleLimitMode = selClim;
  wire [1:0]  levelNext = selClim ? ocSel[1:0] :
                          selLat  ? ocSel[1:0] :
                          `APFM_LEVEL_MIN;
  wire        dcEnabled = (cfg == `APFM_CFG_BTL) ||
                          (cfg == `APFM_CFG_MIXED);
  wire        globalOff = supplyUv | thermLatch_reg | psBusy |
                          ~resetIn_n;
  wire        anyFault  = supplyUv | thermLatch_reg | (|chanLatch_reg);

  // ----------------------------------------------------------------
  // Pin-short check sequencer
  // ----------------------------------------------------------------
  // Runs once after power-on clear; device reset never restarts it
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      psState_reg <= PS_GND;
      psCount_reg <= 16'h0000;
    end else begin
      case (psState_reg)
        PS_GND: begin
          if (cfg == `APFM_CFG_SE) begin
            psState_reg <= PS_DONE;
          end else if (shortGnd) begin
            psCount_reg <= 16'h0000;
          end else if (psCount_reg == STEP_CYC - 16'h0001) begin
            psState_reg <= PS_SUP;
            psCount_reg <= 16'h0000;
          end else begin
            psCount_reg <= psCount_reg + 16'h0001;
          end
        end
        PS_SUP: begin
          if (shortSupply) begin
            psCount_reg <= 16'h0000;
          end else if (psCount_reg == STEP_CYC - 16'h0001) begin
            psState_reg <= PS_DONE;
          end else begin
            psCount_reg <= psCount_reg + 16'h0001;
          end
        end
        PS_DONE: begin
          psState_reg <= PS_DONE;
        end
        default: begin
          psState_reg <= PS_DONE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Reset edge tracker and thermal latch
  // ----------------------------------------------------------------
  // Only a low reset pin clears the thermal latch; heat wins
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      resetPrev_reg  <= 1'b1;
      thermLatch_reg <= 1'b0;
    end else begin
      resetPrev_reg <= resetIn_n;
      if (heatShutdown) begin
        thermLatch_reg <= 1'b1;
      end else if (resetLow) begin
        thermLatch_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-channel overload handling
  // ----------------------------------------------------------------
  // Channel 0 owns bridges A,B; channel 1 owns C,D
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : gChan
      wire evOc = |ocAny[2*ch+1:2*ch];
      wire evDc = dcImbalance[ch] & dcEnabled;
      wire ev   = (evOc & cycleLimitMode) | evDc;
      always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          olCount_reg[ch]   <= 8'h00;
          chanLatch_reg[ch] <= 1'b0;
          chanOc_reg[ch]    <= 1'b0;
        end else begin
          // Latch sets win over a reset-pin clear
          if ((evOc & ~cycleLimitMode) ||
              (olCount_reg[ch] == `APFM_OL_MAX)) begin
            chanLatch_reg[ch] <= 1'b1;
          end else if (resetLow) begin
            chanLatch_reg[ch] <= 1'b0;
          end
          // Count up per event, down per clean frame
          if (resetLow) begin
            olCount_reg[ch] <= 8'h00;
          end else if (ev && olCount_reg[ch] != `APFM_OL_MAX) begin
            olCount_reg[ch] <= olCount_reg[ch] + 8'h01;
          end else if (pwmFrame && !chanOc_reg[ch] && !ev &&
                       olCount_reg[ch] != 8'h00 &&
                       olCount_reg[ch] != `APFM_OL_MAX) begin
            olCount_reg[ch] <= olCount_reg[ch] - 8'h01;
          end
          if (pwmFrame) begin
            chanOc_reg[ch] <= 1'b0;
          end else if (ev) begin
            chanOc_reg[ch] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Per-bridge flip and enable
  // ----------------------------------------------------------------
  genvar hb;
  generate
    for (hb = 0; hb < 4; hb = hb + 1) begin : gBridge
      always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          flip_reg[hb]     <= 1'b0;
          bridgeEnable[hb] <= 1'b0;
        end else begin
          // Frame start clears the flip, events in cycle-limit set it
          if (pwmFrame) begin
            flip_reg[hb] <= 1'b0;
          end else if (ocAny[hb] && cycleLimitMode) begin
            flip_reg[hb] <= 1'b1;
          end
          bridgeEnable[hb] <= ~globalOff & ~chanLatch_reg[hb/2] &
                              ~bootUv[hb];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Pins and derived outputs
  // ----------------------------------------------------------------
  // Open-drain: drive low only, enable high while pulling
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bridgeFlip   <= 4'h0;
      tripLevel    <= `APFM_LEVEL_MIN;
      psTestSupply <= 1'b0;
      faultOut     <= 1'b0;
      faultOe      <= 1'b0;
      warnOut      <= 1'b0;
      warnOe       <= 1'b0;
    end else begin
      bridgeFlip   <= flip_reg;
      tripLevel    <= levelNext;
      psTestSupply <= (psState_reg == PS_SUP);
      faultOut     <= 1'b0;
      warnOut      <= 1'b0;
      if (psBusy) begin
        faultOe <= 1'b1;
      end else if (!resetIn_n) begin
        faultOe <= 1'b0;
      end else begin
        faultOe <= anyFault;
      end
      warnOe <= heatWarning;
    end
  end

  // ----------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------
  wire [31:0] statusWord = {18'h00000, psOk, resetRise, bootUv,
                            thermLatch_reg, chanLatch_reg,
                            psState_reg, supplyUv};
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `APFM_CTRL_RST;
      prdata   <= 32'h0000_0000;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h0000_0000;
        case (paddr)
          `APFM_CTRL_OFF: begin
            if (pwrite) ctrl_reg <= pwdata & 32'h0000_003f;
            else prdata <= ctrl_reg;
          end
          `APFM_STATUS_OFF: begin
            if (!pwrite) prdata <= statusWord;
          end
          `APFM_OLCNT_OFF: begin
            if (!pwrite) prdata <= {16'h0000, olCount_reg[1],
                                    olCount_reg[0]};
          end
          default: begin
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule // apfm_core
`default_nettype wire
